// ===== sbsram_checker.sv
`timescale 1ns/100ps
module sbsram_checker (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic write_en_n,
  input wire logic advance_or_load,
  input wire logic clock_qualify_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic output_enable_n,
  input wire logic dq_host_oe,
  input wire logic dq_dev_oe
);
  logic q;
  logic sel;
  logic ld;
  assign q = !clock_qualify_n;
  assign sel = !chip_select_first_n && chip_select_second &&
               !chip_select_third_n;
  assign ld = q && !advance_or_load;
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  a_float_oe_high: assert property (output_enable_n |-> !dq_dev_oe)
    else $error("data driven with output enable high");
  a_no_contention: assert property (!(dq_dev_oe && dq_host_oe))
    else $error("both ends drive data");
  a_write_float: assert property ((ld && sel && !write_en_n ##1 q)
    |-> ##1 (!dq_dev_oe && dq_host_oe))
    else $error("write slot not owned by host");
  a_read_drive: assert property ((ld && sel && write_en_n ##1 q)
    |-> ##1 (dq_dev_oe || output_enable_n))
    else $error("read data not driven");
  a_desel_float: assert property ((ld && !sel ##1 q)
    |-> ##1 !dq_dev_oe)
    else $error("device drives after deselect");
  a_stall_freeze: assert property
    ((!q ##1 $stable(output_enable_n)) |-> $stable(dq_dev_oe))
    else $error("drive changed on ignored edge");
  a_fresh_load: assert property ((q && !sel ##1 q && sel)
    |-> !advance_or_load)
    else $error("advance right after deselect");
  a_reset_quiet: assert property ($fell(I_SYS_RST) |->
    (write_en_n && !sel && !dq_dev_oe && !dq_host_oe))
    else $error("bus not idle after reset");
endmodule

// ===== sbsram_defines.svh
`ifndef SBSRAM_DEFINES_SVH
`define SBSRAM_DEFINES_SVH
`define SBSRAM_ADDR_W 8
`define SBSRAM_LANES 4
`define SBSRAM_LANE_W 9
`define SBSRAM_DATA_W 36
`define SBSRAM_DEPTH 256
`define SBSRAM_BURST_LEN 4
`define SBSRAM_PAR_BIT 8
`endif

// ===== sbsram_dev.sv
`timescale 1ns/100ps
`include "sbsram_defines.svh"
// Summary of operation
// - address sampled on edge picks location
// - active-low lane selects write byte plus parity
// - write enable sampled only when qualified
// - host drives write enable low to write
// - advance high increments burst counter
// - host loads fresh address after deselect
// - edges with clock qualify high ignored
// - select needs first low, second high, third low
// - output enable low lets data drive
// - output enable high floats data pins
// - float on write, first post-deselect, deselected
// - strap picks interleaved or linear burst
// - qualify high freezes state, not deselect
// - read data pipelined through output register
module sbsram_dev (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  sbsram_if.dev bus,
  output logic o_selected,
  output logic o_busy
);
  // lane arrays feed this word combinationally
  wire [`SBSRAM_DATA_W-1:0] rd_word;
  logic [`SBSRAM_ADDR_W-1:0] base_addr;
  logic [1:0] burst_cnt;
  logic [1:0] next_burst_cnt;
  logic [1:0] next_offset;
  logic [`SBSRAM_ADDR_W-1:0] next_addr;
  logic [`SBSRAM_ADDR_W-1:0] s1_addr;
  logic [`SBSRAM_ADDR_W-1:0] s2_addr;
  logic [`SBSRAM_LANES-1:0] s1_lanes;
  logic [`SBSRAM_LANES-1:0] s2_lanes;
  sbsram_pkg::sbsram_op_t s1_op;
  sbsram_pkg::sbsram_op_t s2_op;
  sbsram_pkg::sbsram_op_t cur_op;
  logic [`SBSRAM_DATA_W-1:0] rd_reg;
  logic rd_drive;
  logic selected;
  logic next_busy;
  logic qual;
  logic chip_sel;
  logic load;
  logic strap;

  assign qual = !bus.clock_qualify_n;
  assign chip_sel = !bus.chip_select_first_n && bus.chip_select_second &&
                    !bus.chip_select_third_n;
  assign load = qual && !bus.advance_or_load;

  // strap caught in reset and held; a live strap would scramble bursts
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      strap <= bus.burst_order_interleaved;
    end
  end

  // interleave xors offset into low bits; linear adds and wraps
  always_comb begin
    next_burst_cnt = burst_cnt + 2'h1;
    if (strap) begin
      next_offset = base_addr[1:0] ^ next_burst_cnt;
    end else begin
      next_offset = base_addr[1:0] + next_burst_cnt;
    end
    next_addr = {base_addr[`SBSRAM_ADDR_W-1:2], next_offset};
  end

  // burst base and offset counter; frozen on ignored edges
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      base_addr <= '0;
      burst_cnt <= '0;
    end else if (load) begin
      base_addr <= bus.addr;
      burst_cnt <= '0;
    end else if (qual && selected) begin
      burst_cnt <= next_burst_cnt;
    end
  end

  // selection is taken at load only, so a burst keeps it
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      selected <= 1'b0;
    end else if (load) begin
      selected <= chip_sel;
    end
  end

  // command decode stage
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      s1_op <= sbsram_pkg::SBSRAM_IDLE;
      s1_addr <= '0;
      s1_lanes <= '0;
    end else if (load) begin
      if (!chip_sel) begin
        s1_op <= sbsram_pkg::SBSRAM_IDLE;
      end else if (!bus.write_en_n) begin
        s1_op <= sbsram_pkg::SBSRAM_WRITE;
        s1_addr <= bus.addr;
        s1_lanes <= ~bus.lane_write_sel_n;
      end else begin
        s1_op <= sbsram_pkg::SBSRAM_READ;
        s1_addr <= bus.addr;
      end
    end else if (qual && selected) begin
      // burst keeps the loaded op; lanes may change word to word
      s1_addr <= next_addr;
      s1_lanes <= ~bus.lane_write_sel_n;
    end else if (qual) begin
      s1_op <= sbsram_pkg::SBSRAM_IDLE;
    end
  end

  // data phase: write data arrives two qualified edges after command
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      s2_op <= sbsram_pkg::SBSRAM_IDLE;
    end else if (qual) begin
      s2_op <= s1_op;
    end
  end

  // a stall leaves both stages untouched, so the data phase stretches
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      s2_addr <= '0;
      s2_lanes <= '0;
    end else if (qual) begin
      s2_addr <= s1_addr;
      s2_lanes <= s1_lanes;
    end
  end

  // the write slot and the read slot line up at stage 2
  assign cur_op = s2_op;

  // one array per lane, parity bit included; no reset, contents undefined
  for (genvar g = 0; g < `SBSRAM_LANES; g++) begin : g_lane
    logic [`SBSRAM_LANE_W-1:0] mem [0:`SBSRAM_DEPTH-1];
    always_ff @(posedge I_CLK) begin
      if (qual && cur_op == sbsram_pkg::SBSRAM_WRITE && s2_lanes[g]) begin
        mem[s2_addr] <= bus.dq[g*`SBSRAM_LANE_W +: `SBSRAM_LANE_W];
      end
    end
    assign rd_word[g*`SBSRAM_LANE_W +: `SBSRAM_LANE_W] = mem[s1_addr];
  end

  // array read at stage 1, output register at stage 2
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rd_reg <= '0;
    end else if (qual) begin
      rd_reg <= rd_word;
    end
  end

  // s1 idle covers deselect and the first cycle out of it
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rd_drive <= 1'b0;
    end else if (qual) begin
      rd_drive <= (s1_op == sbsram_pkg::SBSRAM_READ);
    end
  end

  // output enable is asynchronous so it gates combinationally
  assign bus.dq_dev_out = rd_reg;
  assign bus.dq_dev_oe = rd_drive && !bus.output_enable_n;

  // busy while either pipeline stage holds an access
  always_comb begin
    next_busy = 1'b0;
    if (s1_op != sbsram_pkg::SBSRAM_IDLE) begin
      next_busy = 1'b1;
    end
    if (s2_op != sbsram_pkg::SBSRAM_IDLE) begin
      next_busy = 1'b1;
    end
  end

  // status for the host side, registered like o_busy; dq_dev_oe is gated combinationally
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      o_selected <= 1'b0;
    end else begin
      o_selected <= selected;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= next_busy;
    end
  end
endmodule

// ===== sbsram_host.sv
`timescale 1ns/100ps
`include "sbsram_defines.svh"
module sbsram_host (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  sbsram_if.host bus,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic i_burst,
  input wire logic i_stall,
  input wire logic i_mode_interleaved,
  input wire logic [`SBSRAM_ADDR_W-1:0] i_addr,
  input wire logic [`SBSRAM_LANES-1:0] i_lane_en,
  input wire logic [`SBSRAM_DATA_W-1:0] i_wdata,
  output logic o_rvalid,
  output logic [`SBSRAM_DATA_W-1:0] o_rdata
);
  // pipeline: issue -> device regs (1) -> data phase (2)
  logic [2:0] rd_pipe;
  logic [2:0] wr_pipe;
  logic [`SBSRAM_DATA_W-1:0] wd_pipe [0:2];
  logic desel;
  logic cq_n;
  logic issue;

  assign cq_n = i_stall;
  assign issue = i_req && !i_stall;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      bus.clock_qualify_n <= 1'b0;
      bus.chip_select_first_n <= 1'b1;
      bus.chip_select_second <= 1'b0;
      bus.chip_select_third_n <= 1'b1;
      bus.advance_or_load <= 1'b0;
      bus.write_en_n <= 1'b1;
      bus.lane_write_sel_n <= '1;
      bus.addr <= '0;
      bus.output_enable_n <= 1'b1;
      // strap follows the pin in reset so the device catches the new order
      bus.burst_order_interleaved <= i_mode_interleaved;
      desel <= 1'b1;
    end else begin
      // strap still follows the pin after reset release; changing it mid-run is illegal
      bus.burst_order_interleaved <= i_mode_interleaved;
      bus.clock_qualify_n <= cq_n;
      if (!cq_n) begin
        bus.chip_select_first_n <= !issue;
        bus.chip_select_second <= issue;
        bus.chip_select_third_n <= !issue;
        // fresh load after deselect, never advance
        bus.advance_or_load <= issue && i_burst && !desel;
        bus.write_en_n <= !(issue && i_write);
        bus.lane_write_sel_n <= ~i_lane_en;
        bus.addr <= i_addr;
        bus.output_enable_n <= 1'b0;
        desel <= !issue;
      end
    end
  end

  // track each access to its data phase; frozen while stalled
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rd_pipe <= '0;
      wr_pipe <= '0;
      bus.dq_host_oe <= 1'b0;
      bus.dq_host_out <= '0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      for (int k = 0; k < 3; k++) begin
        wd_pipe[k] <= '0;
      end
    end else begin
      o_rvalid <= 1'b0;
      // stage 0 follows the issue edge, later stages the qualified edges
      if (!cq_n) begin
        rd_pipe[0] <= issue && !i_write;
        wr_pipe[0] <= issue && i_write;
        wd_pipe[0] <= i_wdata;
      end
      if (!bus.clock_qualify_n) begin
        rd_pipe[2:1] <= rd_pipe[1:0];
        wr_pipe[2:1] <= wr_pipe[1:0];
        wd_pipe[1] <= wd_pipe[0];
        wd_pipe[2] <= wd_pipe[1];
        bus.dq_host_oe <= wr_pipe[1];
        bus.dq_host_out <= wd_pipe[1];
        o_rvalid <= rd_pipe[2];
        o_rdata <= bus.dq;
      end
    end
  end
endmodule

// ===== sbsram_if.sv
`timescale 1ns/100ps
`include "sbsram_defines.svh"
interface sbsram_if;
  logic [`SBSRAM_ADDR_W-1:0] addr;
  logic [`SBSRAM_LANES-1:0] lane_write_sel_n;
  logic write_en_n;
  logic advance_or_load;
  logic clock_qualify_n;
  logic chip_select_first_n;
  logic chip_select_second;
  logic chip_select_third_n;
  logic output_enable_n;
  logic burst_order_interleaved;
  logic [`SBSRAM_DATA_W-1:0] dq_host_out;
  logic dq_host_oe;
  logic [`SBSRAM_DATA_W-1:0] dq_dev_out;
  logic dq_dev_oe;
  logic [`SBSRAM_DATA_W-1:0] dq;
  assign dq = dq_dev_oe ? dq_dev_out :
              (dq_host_oe ? dq_host_out : '0);
  modport host (
    output addr, lane_write_sel_n, write_en_n, advance_or_load,
    output clock_qualify_n, chip_select_first_n, chip_select_second,
    output chip_select_third_n, output_enable_n, burst_order_interleaved,
    output dq_host_out, dq_host_oe,
    input dq
  );
  modport dev (
    input addr, lane_write_sel_n, write_en_n, advance_or_load,
    input clock_qualify_n, chip_select_first_n, chip_select_second,
    input chip_select_third_n, output_enable_n, burst_order_interleaved,
    input dq,
    output dq_dev_out, dq_dev_oe
  );
endinterface

// ===== sbsram_pkg.sv
`include "sbsram_defines.svh"
package sbsram_pkg;
  typedef logic [`SBSRAM_ADDR_W-1:0] sbsram_addr_t;
  typedef logic [`SBSRAM_DATA_W-1:0] sbsram_data_t;
  typedef logic [`SBSRAM_LANES-1:0] sbsram_lanes_t;
  typedef enum logic [2:0] {
    SBSRAM_IDLE = 3'h1,
    SBSRAM_READ = 3'h2,
    SBSRAM_WRITE = 3'h4
  } sbsram_op_t;
endpackage

// ===== sync_burst_sram_host_port_tb.sv
`timescale 1ns/100ps
module sync_burst_sram_host_port_tb;
  logic I_CLK = 0;
  logic I_SYS_RST = 1;
  logic req = 0, wr = 0, burst = 0, stall = 0, mode = 1;
  sbsram_pkg::sbsram_addr_t addr = '0;
  sbsram_pkg::sbsram_lanes_t lanes = '0;
  sbsram_pkg::sbsram_data_t wdata = '0, rdata, old;
  logic rvalid;
  logic sel_o;
  logic busy_o;
  sbsram_pkg::sbsram_addr_t ra;
  int n_errors = 0;
  int checked = 0;
  sbsram_if bus();
  sbsram_host u_sbsram_host (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .bus(bus), .i_req(req), .i_write(wr), .i_burst(burst),
    .i_stall(stall), .i_mode_interleaved(mode), .i_addr(addr),
    .i_lane_en(lanes), .i_wdata(wdata), .o_rvalid(rvalid),
    .o_rdata(rdata));
  sbsram_dev u_sbsram_dev (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .bus(bus), .o_selected(sel_o), .o_busy(busy_o));
  sbsram_checker u_sbsram_checker (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .write_en_n(bus.write_en_n), .advance_or_load(bus.advance_or_load),
    .clock_qualify_n(bus.clock_qualify_n),
    .chip_select_first_n(bus.chip_select_first_n),
    .chip_select_second(bus.chip_select_second),
    .chip_select_third_n(bus.chip_select_third_n),
    .output_enable_n(bus.output_enable_n),
    .dq_host_oe(bus.dq_host_oe), .dq_dev_oe(bus.dq_dev_oe));
  initial begin
    forever #2 I_CLK = ~I_CLK;
  end
  task automatic results;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input sbsram_pkg::sbsram_data_t got, exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input sbsram_pkg::sbsram_addr_t a,
    input sbsram_pkg::sbsram_lanes_t l, input sbsram_pkg::sbsram_data_t d,
    input logic b);
    req <= 1;
    wr <= 1;
    burst <= b;
    addr <= a;
    lanes <= l;
    wdata <= d;
    @(posedge I_CLK);
  endtask
  task automatic idle(input int n);
    req <= 0;
    wr <= 0;
    burst <= 0;
    repeat (n) @(posedge I_CLK);
  endtask
  // stall held over the read pipeline to stretch it
  task automatic get(input sbsram_pkg::sbsram_addr_t a,
    input sbsram_pkg::sbsram_data_t e, input logic s);
    int k;
    req <= 1;
    wr <= 0;
    burst <= 0;
    addr <= a;
    for (k = 0; k < 16; k++) begin
      @(posedge I_CLK);
      req <= 0;
      stall <= s && k < 3;
      #1;
      if (rvalid === 1'b1) break;
    end
    cmp({35'h0, rvalid}, 36'h1);
    cmp(rdata, e);
    @(posedge I_CLK);
  endtask
  task automatic run_set(input logic il);
    put(8'h10, 4'hF, 36'h1_2345_6789, 1'b0);
    idle(2);
    get(8'h10, 36'h1_2345_6789, 1'b0);
    put(8'h10, 4'h5, 36'hF_FFFF_FFFF, 1'b0);
    idle(2);
    old = 36'h1_2345_6789;
    old[8:0] = 9'h1FF;
    old[26:18] = 9'h1FF;
    get(8'h10, old, 1'b1);
    // first word asks advance but must load after deselect
    for (int i = 0; i < 4; i++) put(8'h21, 4'hF, {32'hA000_0000, i[3:0]}, 1);
    idle(3);
    for (int i = 0; i < 4; i++) begin
      ra = il ? {6'h08, i[1:0] ^ 2'h1} : {6'h08, i[1:0] + 2'h1};
      get(ra, {32'hA000_0000, i[3:0]}, 1'b0);
    end
    idle(3);
    #1;
    cmp({34'h0, sel_o, busy_o}, 36'h0);
    @(posedge I_CLK);
  endtask
  initial begin
    repeat (5) @(posedge I_CLK);
    I_SYS_RST <= 0;
    run_set(1'b1);
    I_SYS_RST <= 1;
    mode <= 0;
    repeat (5) @(posedge I_CLK);
    I_SYS_RST <= 0;
    run_set(1'b0);
    results();
  end
  initial begin
    repeat (3000) @(posedge I_CLK);
    n_errors++;
    results();
  end
endmodule
